// *** hdl/caf_pkg.sv ***
// Shared constants and carriers for the CAN acceptance filter block.
// Assumes a 16-bit register port addressed by word index.
package caf_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int NUM_FILT = 16;     // Acceptance filters
  localparam int NUM_MASK = 3;      // Acceptance masks
  localparam int AW       = 7;      // Register word-index width
  localparam int DW       = 16;     // Register data width

  // ****************************************************************
  // Register word indices
  // ****************************************************************
  localparam logic [AW-1:0] ADDR_FSID = 7'h00;  // Filter standard id, 16 words
  localparam logic [AW-1:0] ADDR_FEID = 7'h10;  // Filter extended id, 16 words
  localparam logic [AW-1:0] ADDR_MSID = 7'h20;  // Mask standard id, 3 words
  localparam logic [AW-1:0] ADDR_MEID = 7'h24;  // Mask extended id, 3 words
  localparam logic [AW-1:0] ADDR_SEL1 = 7'h28;  // Mask select, filters 0-7
  localparam logic [AW-1:0] ADDR_SEL2 = 7'h29;  // Mask select, filters 8-15
  localparam logic [AW-1:0] ADDR_FEN  = 7'h2a;  // Filter enables
  localparam logic [AW-1:0] ADDR_BP   = 7'h2c;  // Buffer pointers, 4 words
  localparam logic [AW-1:0] ADDR_STAT = 7'h30;  // Last match status

  // ****************************************************************
  // Field positions in the standard-id registers
  // ****************************************************************
  localparam int SID_HI  = 15;
  localparam int SID_LO  = 5;
  localparam int TYPE_B  = 3;       // Frame type / type-match bit
  localparam int EIDH_HI = 1;       // Extended id bits 17:16 live at 1:0

  // ****************************************************************
  // Reset values and codes
  // ****************************************************************
  localparam logic [DW-1:0] FEN_RST  = 16'hffff;
  localparam logic [DW-1:0] SEL_RST  = 16'h0000;
  localparam logic [DW-1:0] BP_RST   = 16'h0000;
  localparam logic [1:0]    SEL_RSVD = 2'h3;     // Reserved mask source
  localparam logic [3:0]    BP_FIFO  = 4'hf;     // Pointer code for FIFO

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic        ext;      // One for an extended-identifier frame
    logic [10:0] sid;      // Standard identifier
    logic [17:0] eid;      // Extended identifier
  } caf_frame_t;

  typedef struct packed {
    logic       valid;     // One-cycle result strobe
    logic       hit;       // Some filter accepted
    logic [3:0] filt;      // Winning filter
    logic [3:0] bufp;      // Target buffer pointer
    logic       fifo;      // Target is the receive FIFO
  } caf_hit_t;

endpackage

// *** hdl/caf_match.sv ***
// CAN acceptance filter: register file, mask logic and hit reporting.
// Assumes frames and register strobes come from logic on clk.
//
// Function
// - Sixteen filters, each with two id registers
// - Filter standard id bits 15:5 compared
// - Extended id 17:16 low bits, 15:0 separate
// - Filter frame type restricts when matching types
// - Type match set needs equal frame type
// - Type match clear ignores frame type bit
// - Mask standard bits zero mean don't care
// - Mask bits 1:0 gate extended 17:16
// - Two-bit selector picks mask 0, 1, 2
// - Filters 0-7 selectors in first register
// - Filters 8-15 selectors in second register
// - Bits 4 and 2 read zero
// - Mask extended register gates bits 15:0
// - Enabled filters only; enables reset set
// - Hit names buffer pointer; 1111 means FIFO
//
// Design decisions made here: the register addresses and the address-and-strobe port.
module caf_match (
  // Clock, reset, enable
  input  wire logic                   clk,
  input  wire logic                   resetn,
  input  wire logic                   ce,
  // Register port
  input  wire logic [caf_pkg::AW-1:0] addr,
  input  wire logic [caf_pkg::DW-1:0] wdata,
  input  wire logic                   wr,
  input  wire logic                   rd,
  output logic      [caf_pkg::DW-1:0] rdata,
  // Received frame from the protocol engine
  input  wire logic                   rx_valid,
  input  wire caf_pkg::caf_frame_t    rx_frame,
  // Match result
  output caf_pkg::caf_hit_t           result
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [15:0][10:0] fsid;   // Filter standard ids
    logic [15:0]       ftyp;   // Filter frame type bits
    logic [15:0][17:0] feid;   // Filter extended ids
    logic [2:0][10:0]  msid;   // Mask standard bits
    logic [2:0]        mtyp;   // Mask type-match bits
    logic [2:0][17:0]  meid;   // Mask extended bits
    logic [15:0][1:0]  msel;   // Mask source per filter
    logic [15:0]       fen;    // Filter enables
    logic [15:0][3:0]  bp;     // Buffer pointer per filter
    logic [15:0]       rdat;   // Read data register
    caf_pkg::caf_hit_t res;    // Result register
    caf_pkg::caf_hit_t last;   // Sticky copy of last result
  } caf_state_t;

  caf_state_t st_q;            // Registered state
  caf_state_t st_d;            // Next state

  logic [15:0] hit_vec;        // Per-filter hit this cycle
  logic [3:0]  win;            // Lowest hitting filter

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Standard-id register image; the holes at 4 and 2 stay zero
  function automatic logic [15:0] sid_img(logic [10:0] s, logic t,
                                          logic [1:0] e);
    sid_img = {s, 1'b0, t, 1'b0, e};
  endfunction

  // One filter against one frame under one mask
  function automatic logic filt_hit(caf_pkg::caf_frame_t f,
                                    logic [10:0] fs, logic ft,
                                    logic [17:0] fe, logic [10:0] ms,
                                    logic mt, logic [17:0] me);
    logic sid_ok;
    logic eid_ok;
    logic typ_ok;
    sid_ok = ((f.sid ^ fs) & ms) == 11'h000;
    eid_ok = ((f.eid ^ fe) & me) == 18'h00000;
    typ_ok = !mt || (f.ext == ft);
    // Standard frames carry no extended part to compare
    filt_hit = typ_ok && sid_ok && (!f.ext || eid_ok);
  endfunction

  // ****************************************************************
  // Matching
  // ****************************************************************
  // All filters in parallel; reserved selector never matches
  always_comb begin
    hit_vec = '0;
    win     = '0;
    for (int i = 0; i < caf_pkg::NUM_FILT; i++) begin
      if (st_q.fen[i] && st_q.msel[i] != caf_pkg::SEL_RSVD) begin
        hit_vec[i] = filt_hit(rx_frame, st_q.fsid[i], st_q.ftyp[i],
                              st_q.feid[i], st_q.msid[st_q.msel[i]],
                              st_q.mtyp[st_q.msel[i]],
                              st_q.meid[st_q.msel[i]]);
      end
    end
    // Lowest index wins when several filters hit
    for (int i = caf_pkg::NUM_FILT - 1; i >= 0; i--) begin
      if (hit_vec[i]) begin
        win = 4'(i);
      end
    end
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    st_d = st_q;
    // Clock enable low freezes everything, the result strobe included
    if (ce) begin
      st_d.res.valid = 1'b0;   // Result strobe is one cycle
      // Register writes
      if (wr) begin
        if (addr[6:4] == caf_pkg::ADDR_FSID[6:4]) begin
          // Unimplemented bits are simply not stored
          st_d.fsid[addr[3:0]] = wdata[caf_pkg::SID_HI:caf_pkg::SID_LO];
          st_d.ftyp[addr[3:0]] = wdata[caf_pkg::TYPE_B];
          st_d.feid[addr[3:0]][17:16] = wdata[caf_pkg::EIDH_HI:0];
        end else if (addr[6:4] == caf_pkg::ADDR_FEID[6:4]) begin
          st_d.feid[addr[3:0]][15:0] = wdata;
        end else if (addr[6:2] == caf_pkg::ADDR_MSID[6:2] &&
                     addr[1:0] != 2'h3) begin
          st_d.msid[addr[1:0]] = wdata[caf_pkg::SID_HI:caf_pkg::SID_LO];
          st_d.mtyp[addr[1:0]] = wdata[caf_pkg::TYPE_B];
          st_d.meid[addr[1:0]][17:16] = wdata[caf_pkg::EIDH_HI:0];
        end else if (addr[6:2] == caf_pkg::ADDR_MEID[6:2] &&
                     addr[1:0] != 2'h3) begin
          st_d.meid[addr[1:0]][15:0] = wdata;
        end else if (addr == caf_pkg::ADDR_SEL1) begin
          st_d.msel[7:0] = wdata;
        end else if (addr == caf_pkg::ADDR_SEL2) begin
          st_d.msel[15:8] = wdata;
        end else if (addr == caf_pkg::ADDR_FEN) begin
          st_d.fen = wdata;
        end else if (addr[6:2] == caf_pkg::ADDR_BP[6:2]) begin
          st_d.bp[addr[1:0]*4 +: 4] = wdata;
        end
        // Other addresses: write ignored
      end
      // Register reads, answered in the next cycle only
      st_d.rdat = '0;
      if (rd) begin
        if (addr[6:4] == caf_pkg::ADDR_FSID[6:4]) begin
          st_d.rdat = sid_img(st_q.fsid[addr[3:0]], st_q.ftyp[addr[3:0]],
                              st_q.feid[addr[3:0]][17:16]);
        end else if (addr[6:4] == caf_pkg::ADDR_FEID[6:4]) begin
          st_d.rdat = st_q.feid[addr[3:0]][15:0];
        end else if (addr[6:2] == caf_pkg::ADDR_MSID[6:2] &&
                     addr[1:0] != 2'h3) begin
          st_d.rdat = sid_img(st_q.msid[addr[1:0]], st_q.mtyp[addr[1:0]],
                              st_q.meid[addr[1:0]][17:16]);
        end else if (addr[6:2] == caf_pkg::ADDR_MEID[6:2] &&
                     addr[1:0] != 2'h3) begin
          st_d.rdat = st_q.meid[addr[1:0]][15:0];
        end else if (addr == caf_pkg::ADDR_SEL1) begin
          st_d.rdat = st_q.msel[7:0];
        end else if (addr == caf_pkg::ADDR_SEL2) begin
          st_d.rdat = st_q.msel[15:8];
        end else if (addr == caf_pkg::ADDR_FEN) begin
          st_d.rdat = st_q.fen;
        end else if (addr[6:2] == caf_pkg::ADDR_BP[6:2]) begin
          st_d.rdat = st_q.bp[addr[1:0]*4 +: 4];
        end else if (addr == caf_pkg::ADDR_STAT) begin
          // Last result: hit, fifo, buffer, filter
          st_d.rdat = {6'h00, st_q.last.hit, st_q.last.fifo,
                       st_q.last.bufp, st_q.last.filt};
        end
        // Unmapped reads return zero
      end
      // Frame result, one cycle after the frame
      if (rx_valid) begin
        st_d.res.valid = 1'b1;
        st_d.res.hit   = |hit_vec;
        st_d.res.filt  = win;
        st_d.res.bufp  = st_q.bp[win];
        st_d.res.fifo  = (|hit_vec) && st_q.bp[win] == caf_pkg::BP_FIFO;
        st_d.last      = st_d.res;
      end
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  // Ids power up unknown in silicon; zero here for determinism
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q      <= '0;
      st_q.fen  <= caf_pkg::FEN_RST;
      st_q.msel <= {2{caf_pkg::SEL_RST}};                          // Two select words
      st_q.bp   <= {4{caf_pkg::BP_RST}};
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from the state flops
  assign rdata  = st_q.rdat;
  assign result = st_q.res;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  a_hit_follows_frame: assert property (
    ce && rx_valid |=> result.valid && result.hit == $past(|hit_vec))
    else $error("hit flag does not follow the filter vector");

  a_disabled_silent: assert property (
    ce && rx_valid && st_q.fen == 16'h0000 |=> !result.hit)
    else $error("disabled filter reported a hit");

  a_reset_enables: assert property (
    $rose(resetn) |-> st_q.fen == caf_pkg::FEN_RST)
    else $error("filter enables not set after reset");

  a_reserved_sel: assert property (
    st_q.msel[15] == caf_pkg::SEL_RSVD |-> !hit_vec[15])
    else $error("reserved mask source produced a hit");

  a_type_match: assert property (
    hit_vec[0] && st_q.mtyp[st_q.msel[0]] |-> rx_frame.ext == st_q.ftyp[0])
    else $error("frame type mismatch accepted");

  a_holes_zero: assert property (
    ce && rd && addr[6:4] == caf_pkg::ADDR_FSID[6:4] |=>
      rdata[4] == 1'b0 && rdata[2] == 1'b0)
    else $error("unimplemented bits read as one");

  a_sel_readback: assert property (
    ce && wr && addr == caf_pkg::ADDR_SEL1 ##1
      ce && rd && addr == caf_pkg::ADDR_SEL1 |=> rdata == $past(wdata, 2))
    else $error("mask select register readback wrong");

  a_buf_pointer: assert property (
    ce && rx_valid && |hit_vec |=> result.bufp == $past(st_q.bp[win]) &&
      result.fifo == ($past(st_q.bp[win]) == caf_pkg::BP_FIFO))
    else $error("buffer pointer not taken from winning filter");

  a_std_ignores_eid: assert property (
    ce && rx_valid && !rx_frame.ext && !st_q.mtyp[st_q.msel[0]] && st_q.fen[0] &&
      st_q.msel[0] != caf_pkg::SEL_RSVD &&
      ((rx_frame.sid ^ st_q.fsid[0]) & st_q.msid[st_q.msel[0]]) == 11'h000
      |-> hit_vec[0])
    else $error("standard frame rejected on extended bits");

  // Frozen clock enable must hold every output
  a_ce_freeze: assert property (
    !ce |=> $stable(result) && $stable(rdata))
    else $error("outputs moved while clock enable was low");

  // Mask holes read zero just like filter holes
  a_mask_holes: assert property (
    ce && rd && addr[6:2] == caf_pkg::ADDR_MSID[6:2] |=>
      rdata[4] == 1'b0 && rdata[2] == 1'b0)
    else $error("unimplemented mask bits read as one");

  // Read data is a one-cycle answer and idles at zero
  a_rdata_idle: assert property (
    ce && !rd |=> rdata == 16'h0000)
    else $error("read data stands without a read");

  // A missed frame flags neither a hit nor the FIFO
  a_miss_no_fifo: assert property (
    ce && rx_valid && !(|hit_vec) |=> !result.hit && !result.fifo)
    else $error("missed frame reported a target");

  c_hit:      cover property (ce && rx_valid && |hit_vec);
  c_miss:     cover property (ce && rx_valid && !(|hit_vec));
  c_fifo:     cover property (result.valid && result.fifo);
  c_ext_hit:  cover property (ce && rx_valid && rx_frame.ext && |hit_vec);
  c_frozen:   cover property (!ce && wr);

endmodule

// *** sim/caf_node_model.sv ***
// Frame source standing in for the other nodes on the bus.
// Assumes a caller that enters send from the bench's own process on clk.
module caf_node_model (
  // Clock
  input  wire logic           clk,
  // Frame towards the filter
  output logic                rx_valid,
  output caf_pkg::caf_frame_t rx_frame
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // Frame driver
  // ****************************************************************
  // Quiet lines at time zero
  initial begin
    rx_valid = 1'b0;
    rx_frame = '0;
  end

  // One frame in a one-cycle pulse; released lines show the inverse,
  // so a design that samples late sees garbage, not a stale frame
  task automatic send(input caf_pkg::caf_frame_t f);
    @(posedge clk);
    rx_frame <= f;
    rx_valid <= 1'b1;
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_frame <= ~f;
  endtask
endmodule

// *** sim/caf_match_tb.sv ***
// Self-checking bench for the acceptance filter match block.
// Assumes the register port and frame input both run on clk.
module caf_match_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // Signals
  // ****************************************************************
  logic                   clk;      // 40 MHz
  logic                   resetn;   // Async, active low
  logic                   ce;       // Clock enable
  logic [caf_pkg::AW-1:0] addr;     // Register word index
  logic [caf_pkg::DW-1:0] wdata;    // Write data
  logic                   wr;       // Write strobe
  logic                   rd;       // Read strobe
  logic [caf_pkg::DW-1:0] rdata;    // Read data
  logic                   rx_valid; // Frame strobe
  caf_pkg::caf_frame_t    rx_frame; // Frame fields
  caf_pkg::caf_hit_t      result;   // Match result
  int                     failures; // Mismatch count
  int                     checks;   // Comparison count

  always #12.5 clk = ~clk;

  caf_match i_caf_match (.clk(clk), .resetn(resetn), .ce(ce), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .rx_valid(rx_valid), .rx_frame(rx_frame),
    .result(result));
  caf_node_model i_caf_node_model (.clk(clk), .rx_valid(rx_valid), .rx_frame(rx_frame));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  // Verdict and end of run, also reached by the watchdog
  task automatic wrap_up();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk_word(string n, logic [15:0] e, logic [15:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_res(string n, caf_pkg::caf_hit_t e, caf_pkg::caf_hit_t g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  // Leading edge wait keeps strobe drop and next rise in separate steps
  task automatic wr_reg(logic [6:0] a, logic [15:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd_chk(logic [6:0] a, logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    chk_word("rdata", e, rdata);
  endtask

  // Send one frame and judge the result pulse one cycle later
  task automatic tx_chk(logic e, logic [10:0] s, logic [17:0] d, logic h, logic [3:0] f,
                        logic [3:0] b, logic o);
    i_caf_node_model.send(caf_pkg::caf_frame_t'{e, s, d});
    #1;
    chk_res("result", caf_pkg::caf_hit_t'{1'b1, h, f, b, o}, result);
  endtask

  // Filter standard word: gaps at bits 4 and 2
  function automatic logic [15:0] fsid(logic [10:0] s, logic t, logic [1:0] eh);
    return {s, 1'b0, t, 1'b0, eh};
  endfunction

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    chk_res("result", caf_pkg::caf_hit_t'(0), result);
    rd_chk(caf_pkg::ADDR_FEN, 16'hffff);
    rd_chk(caf_pkg::ADDR_SEL1, 16'h0000);
    rd_chk(caf_pkg::ADDR_SEL2, 16'h0000);
  endtask

  task automatic t_regs();
    wr_reg(caf_pkg::ADDR_FSID + 7'h0f, 16'hffff);
    rd_chk(caf_pkg::ADDR_FSID + 7'h0f, 16'hffeb);
    wr_reg(caf_pkg::ADDR_MSID + 7'h2, 16'hffff);
    rd_chk(caf_pkg::ADDR_MSID + 7'h2, 16'hffeb);
    wr_reg(caf_pkg::ADDR_FEID + 7'h0f, 16'ha5c3);
    rd_chk(caf_pkg::ADDR_FEID + 7'h0f, 16'ha5c3);
    // Frozen clock enable must drop the write
    @(posedge clk);
    ce <= 1'b0;
    wr_reg(caf_pkg::ADDR_FEID + 7'h0f, 16'h1111);
    ce <= 1'b1;
    rd_chk(caf_pkg::ADDR_FEID + 7'h0f, 16'ha5c3);
    // Word past the third mask is a hole
    wr_reg(7'h23, 16'hffff);
    rd_chk(7'h23, 16'h0000);
    // Write then read with no gap; no filter in use picks code 11
    @(posedge clk);
    addr  <= caf_pkg::ADDR_SEL1;
    wdata <= 16'h2468;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    rd    <= 1'b1;
    @(posedge clk);
    rd    <= 1'b0;
    #1;
    chk_word("rdata", 16'h2468, rdata);
  endtask

  task automatic t_std();
    wr_reg(caf_pkg::ADDR_FEN, 16'h0001);
    wr_reg(caf_pkg::ADDR_BP, 16'h0007);
    wr_reg(caf_pkg::ADDR_FSID, fsid(11'h5a3, 1'b0, 2'h0));
    wr_reg(caf_pkg::ADDR_MSID, 16'hffe0);
    tx_chk(1'b0, 11'h5a3, 18'h0, 1'b1, 4'h0, 4'h7, 1'b0);
    tx_chk(1'b0, 11'h5a2, 18'h0, 1'b0, 4'h0, 4'h7, 1'b0);
    wr_reg(caf_pkg::ADDR_MSID, 16'hffc0);
    tx_chk(1'b0, 11'h5a2, 18'h0, 1'b1, 4'h0, 4'h7, 1'b0);
  endtask

  task automatic t_ext();
    wr_reg(caf_pkg::ADDR_MSID, 16'hffe3);
    wr_reg(caf_pkg::ADDR_MEID, 16'hffff);
    wr_reg(caf_pkg::ADDR_FSID, fsid(11'h5a3, 1'b0, 2'h2));
    wr_reg(caf_pkg::ADDR_FEID, 16'h1234);
    tx_chk(1'b1, 11'h5a3, 18'h21234, 1'b1, 4'h0, 4'h7, 1'b0);
    tx_chk(1'b1, 11'h5a3, 18'h11234, 1'b0, 4'h0, 4'h7, 1'b0);
    tx_chk(1'b1, 11'h5a3, 18'h21235, 1'b0, 4'h0, 4'h7, 1'b0);
    tx_chk(1'b0, 11'h5a3, 18'h00000, 1'b1, 4'h0, 4'h7, 1'b0);
    wr_reg(caf_pkg::ADDR_MEID, 16'hfffe);
    tx_chk(1'b1, 11'h5a3, 18'h21235, 1'b1, 4'h0, 4'h7, 1'b0);
    wr_reg(caf_pkg::ADDR_MSID, 16'hffe1);
    tx_chk(1'b1, 11'h5a3, 18'h01234, 1'b1, 4'h0, 4'h7, 1'b0);
  endtask

  task automatic t_type();
    wr_reg(caf_pkg::ADDR_MSID, 16'hffeb);
    tx_chk(1'b1, 11'h5a3, 18'h21234, 1'b0, 4'h0, 4'h7, 1'b0);
    tx_chk(1'b0, 11'h5a3, 18'h00000, 1'b1, 4'h0, 4'h7, 1'b0);
    wr_reg(caf_pkg::ADDR_FSID, fsid(11'h5a3, 1'b1, 2'h2));
    tx_chk(1'b1, 11'h5a3, 18'h21234, 1'b1, 4'h0, 4'h7, 1'b0);
    tx_chk(1'b0, 11'h5a3, 18'h00000, 1'b0, 4'h0, 4'h7, 1'b0);
  endtask

  task automatic t_select();
    wr_reg(caf_pkg::ADDR_MSID + 7'h1, 16'h0000);
    wr_reg(caf_pkg::ADDR_MEID + 7'h1, 16'h0000);
    wr_reg(caf_pkg::ADDR_MSID + 7'h2, 16'hffe0);
    wr_reg(caf_pkg::ADDR_MEID + 7'h2, 16'h0000);
    wr_reg(caf_pkg::ADDR_FSID + 7'h07, fsid(11'h111, 1'b0, 2'h0));
    wr_reg(caf_pkg::ADDR_FSID + 7'h0f, fsid(11'h222, 1'b0, 2'h0));
    wr_reg(caf_pkg::ADDR_FEN, 16'h8080);
    wr_reg(caf_pkg::ADDR_SEL1, 16'h4000);
    wr_reg(caf_pkg::ADDR_SEL2, 16'h8000);
    wr_reg(caf_pkg::ADDR_BP + 7'h1, 16'h9000);
    wr_reg(caf_pkg::ADDR_BP + 7'h3, 16'hf000);
    tx_chk(1'b0, 11'h222, 18'h0, 1'b1, 4'h7, 4'h9, 1'b0);
    wr_reg(caf_pkg::ADDR_SEL1, 16'h8000);
    tx_chk(1'b0, 11'h222, 18'h0, 1'b1, 4'hf, 4'hf, 1'b1);
    rd_chk(caf_pkg::ADDR_STAT, 16'h03ff);
    wr_reg(caf_pkg::ADDR_SEL2, 16'hc000);
    tx_chk(1'b0, 11'h222, 18'h0, 1'b0, 4'h0, 4'h7, 1'b0);
    wr_reg(caf_pkg::ADDR_SEL1, 16'h4000);
    wr_reg(caf_pkg::ADDR_FEN, 16'h0000);
    tx_chk(1'b0, 11'h222, 18'h0, 1'b0, 4'h0, 4'h7, 1'b0);
  endtask

  // Reset in mid-run clears the outputs and sets the enables again
  task automatic t_rerst();
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk_res("result", caf_pkg::caf_hit_t'(0), result);
    chk_word("rdata", 16'h0000, rdata);
    @(posedge clk);
    resetn <= 1'b1;
    rd_chk(caf_pkg::ADDR_FEN, 16'hffff);
    rd_chk(caf_pkg::ADDR_SEL2, 16'h0000);
  endtask

  // ****************************************************************
  // Main sequence and watchdog
  // ****************************************************************
  initial begin
    clk      = 1'b0;
    resetn   = 1'b0;
    ce       = 1'b1;
    addr     = '0;
    wdata    = '0;
    wr       = 1'b0;
    rd       = 1'b0;
    failures = 0;
    checks   = 0;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    t_reset();
    t_regs();
    t_std();
    t_ext();
    t_type();
    t_select();
    t_rerst();
    wrap_up();
  end

  // Hang guard: a run this long counts as a mismatch
  initial begin
    repeat (4000) @(posedge clk);
    failures++;
    wrap_up();
  end
endmodule
